// ==== design/dwdt_pkg.sv ====
// Package of constants shared by the dual watchdog design.
// Assumes a single 50 MHz clock and slow-oscillator ticks arriving as enables.
// ********************************************************************
// What this block does
// ********************************************************************
package dwdt_pkg;
  localparam int          CNT_W      = 13;
  localparam logic [12:0] CNT_RST    = 13'h0FFF;  // Largest positive start value.
  localparam logic [12:0] CNT_ZERO   = 13'h0000;
  localparam logic [12:0] CNT_RESET  = 13'h1FF0;  // Minus sixteen.
  localparam int          MAX_LP_S   = 84;        // Seconds on the low-power RC.
  localparam int          MAX_ALT_S  = 180;       // Seconds on the alternative RC.
endpackage

// ==== design/dwdt_cnt_if.sv ====
// Interface carrying one watchdog's control and status.
// Assumes both ends run on ref_clk_i.
`timescale 1ns/1ps
interface dwdt_cnt_if;
  logic        tick;
  logic        freeze;
  logic        reload;
  logic [12:0] reload_val;
  logic [12:0] count;
  logic        irq;
  logic        rst_req;
  modport ctl (output tick, freeze, reload, reload_val, input count, irq, rst_req);
  modport cnt (input tick, freeze, reload, reload_val, output count, irq, rst_req);
endinterface

// ==== design/dwdt_counter.sv ====
// One 13-bit signed down-counting watchdog.
// Assumes tick is a one-cycle enable from the slow oscillator.
`timescale 1ns/1ps
module dwdt_counter (
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  dwdt_cnt_if.cnt   bus
);
  // ********************************************************************
  // Counter
  // ********************************************************************
  logic [12:0] cnt_r;

  // Counts down on each unfrozen tick until minus sixteen, where it holds; a reload wins over the tick.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cnt_r <= dwdt_pkg::CNT_RST;
    end else if (bus.reload) begin
      cnt_r <= bus.reload_val;
    end else if (bus.tick && !bus.freeze && $signed(cnt_r) > $signed(dwdt_pkg::CNT_RESET)) begin
      cnt_r <= cnt_r - 13'h0001;
    end
  end

  // Signed compare: zero or below raises the interrupt, minus sixteen the reset.
  assign bus.count   = cnt_r;
  assign bus.irq     = ($signed(cnt_r) <= $signed(dwdt_pkg::CNT_ZERO));
  // A reload below minus sixteen counts as past the reset point as well.
  assign bus.rst_req = ($signed(cnt_r) <= $signed(dwdt_pkg::CNT_RESET));

  AST_FREEZE_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    bus.freeze && !bus.reload |=> cnt_r == $past(cnt_r))
    else $error("Counter moved while frozen.");
  AST_DEC: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    bus.tick && !bus.freeze && !bus.reload && !bus.rst_req
    |=> cnt_r == $past(cnt_r) - 13'h0001)
    else $error("Counter did not decrement.");
  AST_RELOAD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    bus.reload |=> cnt_r == $past(bus.reload_val))
    else $error("Reload not taken.");
  AST_IRQ_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    cnt_r == dwdt_pkg::CNT_ZERO |-> bus.irq && !bus.rst_req)
    else $error("Zero did not interrupt.");
  AST_RST_M16: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $signed(cnt_r) > $signed(dwdt_pkg::CNT_RESET) |-> !bus.rst_req)
    else $error("Reset raised too early.");

  // The interface carries 13-bit counts; refuse any other width.
  if (dwdt_pkg::CNT_W != 13) begin : g_width_chk
    $error("Counter width must be 13 bits.");
  end
endmodule // dwdt_counter

// ==== design/dwdt_top.sv ====
// Top of the dual watchdog: system and radio CPU watchdogs.
// Assumes slow oscillator ticks arrive as one-cycle enables on ref_clk_i.
// Assumes reloads and debug halts are synchronous levels or pulses from the CPUs.
// Assumes the reset logic outside acts on hw_reset_o and later pulls rstn_i low.
`timescale 1ns/1ps
module dwdt_top (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        sys_tick_i,
  input  wire logic        radio_tick_i,
  input  wire logic        sys_debug_halt_i,
  input  wire logic        radio_debug_halt_i,
  input  wire logic        sys_reload_i,
  input  wire logic [12:0] sys_reload_val_i,
  input  wire logic        radio_reload_i,
  input  wire logic [12:0] radio_reload_val_i,
  output logic [12:0]      sys_count_o,
  output logic [12:0]      radio_count_o,
  output logic             sys_nmi_o,
  output logic             radio_irq_o,
  output logic             hw_reset_o
);
  // ********************************************************************
  // Watchdog instances
  // ********************************************************************
  dwdt_cnt_if sys_if ();
  dwdt_cnt_if rad_if ();
  logic       freeze;

  // Either CPU in debug halts both counters. A single shared freeze keeps
  // the two watchdogs in step, so a debugger stopping one CPU never lets
  // the other CPU's watchdog fire behind its back.
  assign freeze            = sys_debug_halt_i | radio_debug_halt_i;
  assign sys_if.tick       = sys_tick_i;     // Always-on tick, never gated by sleep.
  assign sys_if.freeze     = freeze;
  assign sys_if.reload     = sys_reload_i;
  assign sys_if.reload_val = sys_reload_val_i;
  assign rad_if.tick       = radio_tick_i;
  assign rad_if.freeze     = freeze;
  assign rad_if.reload     = radio_reload_i;
  assign rad_if.reload_val = radio_reload_val_i;

  // ********************************************************************
  // Count span and shared decoding
  // ********************************************************************
  // The longest watchdog time is the number of ticks from the reset value
  // down to the reset point. The tick rate comes from the slow oscillator
  // outside this block, so the span in seconds follows the chosen source:
  // the alternative oscillator gives the longer time, the low-power one the
  // shorter. Nothing here counts seconds; the span is fixed in ticks.
  localparam int SPAN_TICKS = int'(dwdt_pkg::CNT_RST)
                            - int'($signed(dwdt_pkg::CNT_RESET));

  // Swapped span constants would mislabel the two oscillators; refuse them.
  if (dwdt_pkg::MAX_ALT_S <= dwdt_pkg::MAX_LP_S) begin : g_span_chk
    $error("Alternative oscillator span must exceed the low-power span.");
  end

  // A reset value at or below zero would leave no interrupt before reset.
  if (SPAN_TICKS <= -int'($signed(dwdt_pkg::CNT_RESET))) begin : g_reach_chk
    $error("Reset value must lie above zero.");
  end

  // Both watchdogs decode status the same way; the checks below share this.
  function automatic logic at_or_below(input logic [12:0] c, input logic [12:0] lim);
    return $signed(c) <= $signed(lim);
  endfunction

  // Two separate 13-bit counters. The system one sits in the always-on
  // domain and the radio one in the radio domain; here they share the
  // clock and reset, and only their ticks and reloads differ.
  dwdt_counter u_sys (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .bus(sys_if));
  dwdt_counter u_rad (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .bus(rad_if));

  // ********************************************************************
  // Registered outputs
  // ********************************************************************
  // Each output has its own register, so the counts and the event lines
  // stand one clock behind the counters and never glitch on a compare.

  // System count as seen by the system CPU.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      sys_count_o <= dwdt_pkg::CNT_RST;
    end else begin
      sys_count_o <= sys_if.count;
    end
  end

  // Radio count as seen by the radio CPU.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      radio_count_o <= dwdt_pkg::CNT_RST;
    end else begin
      radio_count_o <= rad_if.count;
    end
  end

  // Non-maskable interrupt level to the system CPU.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      sys_nmi_o <= 1'b0;
    end else begin
      sys_nmi_o <= sys_if.irq;
    end
  end

  // Ordinary interrupt level to the radio CPU.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      radio_irq_o <= 1'b0;
    end else begin
      radio_irq_o <= rad_if.irq;
    end
  end

  // Hardware reset request from either watchdog.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      hw_reset_o <= 1'b0;
    end else begin
      hw_reset_o <= sys_if.rst_req | rad_if.rst_req;
    end
  end

  // ********************************************************************
  // Freeze run tracking
  // ********************************************************************
  // Counts cycles in which debug holds both counters and no reload arrives.
  // A long run lets one check look back over many cycles without a long
  // repetition in the property.
  logic [7:0] hold_run_r;

  // Saturating run length; any reload or the end of the halt starts over.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      hold_run_r <= 8'h00;
    end else if (!freeze || sys_reload_i || radio_reload_i) begin
      hold_run_r <= 8'h00;
    end else if (hold_run_r != 8'hFF) begin
      hold_run_r <= hold_run_r + 8'h01;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  // Outputs are checked against the counters one cycle earlier, and the
  // counters against the shared decoding, so a fault is pinned to a stage.

  AST_RESET_OUT: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (sys_if.rst_req || rad_if.rst_req) |=> hw_reset_o)
    else $error("Hardware reset not raised.");
  AST_NMI_OUT: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    sys_if.irq |=> sys_nmi_o)
    else $error("NMI not raised.");
  AST_RAD_IRQ: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !rad_if.irq |=> !radio_irq_o)
    else $error("Spurious radio interrupt.");
  COV_NMI:   cover property (@(posedge ref_clk_i) disable iff (!rstn_i) $rose(sys_nmi_o));
  COV_RST:   cover property (@(posedge ref_clk_i) disable iff (!rstn_i) $rose(hw_reset_o));
  COV_FRZ:   cover property (@(posedge ref_clk_i) disable iff (!rstn_i) freeze && sys_tick_i);
  COV_RIRQ:  cover property (@(posedge ref_clk_i) disable iff (!rstn_i) $rose(radio_irq_o));
  COV_RCLR:  cover property (@(posedge ref_clk_i) disable iff (!rstn_i) $fell(hw_reset_o));

  // The interrupt drops one cycle after the system count leaves zero or below.
  AST_NMI_LOW: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !sys_if.irq |=> !sys_nmi_o)
    else $error("NMI raised with system count above zero.");

  // The radio interrupt follows its counter.
  AST_RAD_IRQ_HIGH: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    rad_if.irq |=> radio_irq_o)
    else $error("Radio interrupt missing.");

  // No reset request without a counter at the reset point.
  AST_RESET_LOW: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !(sys_if.rst_req || rad_if.rst_req) |=> !hw_reset_o)
    else $error("Hardware reset raised without cause.");

  // The system count output lags its counter by one cycle.
  AST_SYS_CNT_OUT: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    1'b1 |=> sys_count_o == $past(sys_if.count))
    else $error("System count output stale.");

  // The radio count output lags its counter by one cycle.
  AST_RAD_CNT_OUT: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    1'b1 |=> radio_count_o == $past(rad_if.count))
    else $error("Radio count output stale.");

  // System status decodes at zero and at the reset point.
  AST_SYS_DECODE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    sys_if.irq == at_or_below(sys_if.count, dwdt_pkg::CNT_ZERO)
    && sys_if.rst_req == at_or_below(sys_if.count, dwdt_pkg::CNT_RESET))
    else $error("System status decode wrong.");

  // Radio status decodes at zero and at the reset point.
  AST_RAD_DECODE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    rad_if.irq == at_or_below(rad_if.count, dwdt_pkg::CNT_ZERO)
    && rad_if.rst_req == at_or_below(rad_if.count, dwdt_pkg::CNT_RESET))
    else $error("Radio status decode wrong.");

  // Eight frozen cycles without reload leave both counts where they were.
  AST_FREEZE_RUN: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    hold_run_r == 8'h08 |-> sys_if.count == $past(sys_if.count, 8)
    && rad_if.count == $past(rad_if.count, 8))
    else $error("Count moved during a debug halt.");

  // Once at the reset point the system watchdog stays there until reloaded.
  AST_RST_STICKS: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    sys_if.rst_req && !sys_reload_i |=> sys_if.rst_req)
    else $error("System reset request dropped without reload.");
endmodule // dwdt_top

// ==== bench/dwdt_osc_model.sv ====
// Slow oscillator model that drives both watchdog count enables.
// Assumes ref_clk_i from the bench; DIV stands in for the slow period.
`timescale 1ns/1ps
module dwdt_osc_model #(parameter int DIV = 3) (
  input  wire logic ref_clk_i,
  input  wire logic en_i,
  output logic      sys_tick_o = 1'b0,
  output logic      radio_tick_o = 1'b0
);
  int cnt_r = 0;
  // One-cycle ticks, the radio tick one cycle after the system tick.
  always @(posedge ref_clk_i) begin
    cnt_r <= (cnt_r + 1) % DIV;
    sys_tick_o <= en_i && (cnt_r == 0);
    radio_tick_o <= en_i && (cnt_r == 1);
  end
endmodule // dwdt_osc_model

// ==== bench/tb.sv ====
// Self-checking bench for the dual watchdog top.
// Assumes the oscillator model supplies ticks and the bench plays both CPUs.
`timescale 1ns/1ps
module tb;
  logic        ref_clk_i = 1'b0, rstn_i = 1'b0, osc_en = 1'b0;
  logic        s_halt = 1'b0, r_halt = 1'b0, s_rel = 1'b0, r_rel = 1'b0;
  logic [12:0] s_val = 13'h0000, r_val = 13'h0000, s_cnt, r_cnt, s_m, r_m, s_md, r_md;
  logic        s_tick, r_tick, nmi, irq, hwr;
  int          error_cnt = 0, num_checks = 0, cyc = 0;
  dwdt_osc_model #(.DIV(3)) u_dwdt_osc_model (.ref_clk_i(ref_clk_i), .en_i(osc_en),
    .sys_tick_o(s_tick), .radio_tick_o(r_tick));
  dwdt_top u_dwdt_top (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .sys_tick_i(s_tick),
    .radio_tick_i(r_tick), .sys_debug_halt_i(s_halt), .radio_debug_halt_i(r_halt),
    .sys_reload_i(s_rel), .sys_reload_val_i(s_val), .radio_reload_i(r_rel),
    .radio_reload_val_i(r_val), .sys_count_o(s_cnt), .radio_count_o(r_cnt),
    .sys_nmi_o(nmi), .radio_irq_o(irq), .hw_reset_o(hwr));
  initial forever #10 ref_clk_i = ~ref_clk_i;
  // Next count: a reload wins, a halt freezes, minus sixteen sticks.
  function automatic logic [12:0] nxt(logic [12:0] c, logic t, logic rel, logic [12:0] v);
    if (rel) return v;
    if (t && !s_halt && !r_halt && $signed(c) > $signed(dwdt_pkg::CNT_RESET))
      return c - 13'h0001;
    return c;
  endfunction
  task automatic check(string n, logic [12:0] seen, logic [12:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reference counters follow the inputs seen at each edge; outputs lag one cycle.
  always @(posedge ref_clk_i) begin
    s_md <= s_m;
    r_md <= r_m;
    cyc <= cyc + 1;
    s_m <= rstn_i ? nxt(s_m, s_tick, s_rel, s_val) : dwdt_pkg::CNT_RST;
    r_m <= rstn_i ? nxt(r_m, r_tick, r_rel, r_val) : dwdt_pkg::CNT_RST;
  end
  // A hang ends the run as a failure.
  always @(posedge ref_clk_i) if (cyc == 6000) begin
    error_cnt++;
    wrap_up();
  end
  // Outputs are compared once settled, away from the sampling edge.
  always @(negedge ref_clk_i) if (rstn_i && cyc > 4) begin
    check("sys_count", s_cnt, s_md);
    check("radio_count", r_cnt, r_md);
    check("sys_nmi", nmi, 13'($signed(s_md) <= 0));
    check("radio_irq", irq, 13'($signed(r_md) <= 0));
    check("hw_reset", hwr, 13'($signed(s_md) <= $signed(dwdt_pkg::CNT_RESET)
      || $signed(r_md) <= $signed(dwdt_pkg::CNT_RESET)));
  end
  // Free run from reset, a reload near zero down to the stuck end, then random play.
  initial begin
    void'($urandom(96560));
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    osc_en <= 1'b1;
    repeat (30) @(posedge ref_clk_i);
    s_rel <= 1'b1; s_val <= 13'h0002; r_rel <= 1'b1; r_val <= 13'h0001;
    @(posedge ref_clk_i);
    s_rel <= 1'b0; r_rel <= 1'b0;
    repeat (80) @(posedge ref_clk_i);
    s_halt <= 1'b1;
    repeat (12) @(posedge ref_clk_i);
    s_halt <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    repeat (4000) begin
      @(posedge ref_clk_i);
      s_halt <= ($urandom % 8) == 0;
      r_halt <= ($urandom % 8) == 0;
      s_rel <= ($urandom % 40) == 0;
      r_rel <= ($urandom % 40) == 0;
      s_val <= 13'($urandom % 48) - 13'h0018;
      r_val <= 13'($urandom % 48) - 13'h0018;
    end
    rstn_i <= 1'b0;
    s_halt <= 1'b0;
    r_halt <= 1'b0;
    s_rel <= 1'b0;
    r_rel <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (200) @(posedge ref_clk_i);
    wrap_up();
  end
endmodule // tb
